// ---- core/cfd_core.sv ----
// Behaviour
// - relative target is address plus two plus sign-extended offset byte
// - half-carry takes carry out of bit 3, carry out of bit 7
// - branch to subroutine, opcode 8d, two bytes, eight cycles
// - return from subroutine, opcode 39, one byte, five cycles
// - return from interrupt, opcode 3b, one byte, ten cycles
// - return from interrupt reloads all flags from the stack
// - software trap, opcode 3f, one byte, twelve cycles
// - halt until interrupt, opcode 3e, one byte, nine cycles
// - waking sets the mask; with mask already set only nmi wakes
// - no operation, opcode 02, two cycles, advances address only
// - opcodes 0c, 0e, 0a clear carry, mask, overflow only
// - opcodes 0d, 0f, 0b set carry, mask, overflow only
// - sixteen-bit result negative when bit 15 is one
// - decimal adjust sets carry above nine, never clears it
// - sixteen-bit compare overflow comes from high byte subtraction
// - transfer to flags loads every flag from accumulator a
// - mask is flag bit 4; bits 6 and 7 read one
// - trap and halt push address, index, accumulators, flags
// - trap vector high byte at fffa, low byte at fffb
`timescale 1ns/100ps
module cfd_core
	import cfd_pkg::*;
#(
	parameter int CPU_DIV_P = CPU_DIV
) (
	input logic aclk,
	input logic aresetn,
	input logic s_axi_awvalid,
	output logic s_axi_awready,
	input logic [AXI_AW-1:0] s_axi_awaddr,
	input logic s_axi_wvalid,
	output logic s_axi_wready,
	input logic [31:0] s_axi_wdata,
	input logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input logic s_axi_arvalid,
	output logic s_axi_arready,
	input logic [AXI_AW-1:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic [15:0] mem_addr,
	output logic mem_rd,
	output logic mem_wr,
	output logic [7:0] mem_wdata,
	input logic [7:0] mem_rdata,
	input logic irq_n,
	input logic nmi_n
);
	localparam int DW = $clog2(CPU_DIV_P + 1);

	function automatic logic [3:0] cfd_ncyc(input logic [7:0] op);
		case (op)
			OP_BSR: return NC_BSR;
			OP_RTS: return NC_RTS;
			OP_RTI: return NC_RTI;
			OP_SWI, OP_INT: return NC_SWI;
			OP_WAI: return NC_WAI;
			OP_CLR_EXT: return NC_CLR_EXT;
			OP_CLR_IDX: return NC_CLR_IDX;
			default: return NC_SHORT;
		endcase
	endfunction

	// bus action of cycle c of an instruction; cycle 0 is the fetch
	function automatic logic [3:0] cfd_act(input logic [7:0] op,
		input logic [3:0] c);
		logic stack7;
		stack7 = (c >= 4'h2) && (c <= 4'h8);
		case (op)
			OP_BSR: return (c == 4'h1) ? ACT_RD1 :
				((c == 4'h3) || (c == 4'h4)) ? ACT_PUSH : ACT_IDLE;
			OP_RTS: return ((c == 4'h2) || (c == 4'h3)) ? ACT_PULL : ACT_IDLE;
			OP_RTI: return stack7 ? ACT_PULL : ACT_IDLE;
			OP_SWI, OP_INT: return stack7 ? ACT_PUSH :
				(c == 4'ha) ? ACT_VHI : (c == 4'hb) ? ACT_VLO : ACT_IDLE;
			OP_WAI: return stack7 ? ACT_PUSH : ACT_IDLE;
			OP_CLR_EXT: return (c == 4'h1) ? ACT_RD1 : (c == 4'h2) ? ACT_RD2 :
				(c == 4'h5) ? ACT_WR0 : ACT_IDLE;
			OP_CLR_IDX: return (c == 4'h1) ? ACT_RD1 :
				(c == 4'h6) ? ACT_WR0 : ACT_IDLE;
			OP_WAKE: return (c == 4'h1) ? ACT_VLO : ACT_IDLE;
			default: return ACT_IDLE;
		endcase
	endfunction

	function automatic logic cfd_legal(input logic [7:0] op);
		case (op)
			OP_BSR, OP_RTS, OP_RTI, OP_SWI, OP_WAI, OP_NOP, OP_CLEAR_ACCUMULATOR_A, OP_CLEAR_ACCUMULATOR_B,
			OP_CLR_EXT, OP_CLR_IDX, OP_CLC, OP_CLI, OP_CLV, OP_SEC, OP_SEI,
			OP_SEV: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	function automatic logic [15:0] cfd_merge16(input logic [15:0] old,
		input logic [15:0] nw, input logic [1:0] strb);
		return {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
	endfunction

	cfd_state_type state_q, state_d;
	logic [DW-1:0] div_q;
	logic [3:0] step_q, step_d;
	logic [7:0] op_q, op_d;
	logic [2:0] stk_q, stk_d;
	logic [15:0] tmp_q, tmp_d, ret_q, ret_d, vec_q, vec_d;
	logic [15:0] pc_q, pc_d, sp_q, sp_d, ix_q, ix_d;
	logic [7:0] a_q, a_d, b_q, b_d;
	logic [5:0] ccr_q, ccr_d;
	logic run_q, run_d, ill_q, ill_d, fetch_q, fetch_d;
	logic nmi_pend_q, nmi_pend_d;
	logic [15:0] mem_addr_q, mem_addr_d;
	logic mem_rd_q, mem_rd_d, mem_wr_q, mem_wr_d;
	logic [7:0] mem_wdata_q, mem_wdata_d;
	logic [2:0] irq_s_q, nmi_s_q;
	logic irq_f_q, nmi_f_q;
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic aw_have_q, w_have_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q, w_data_q;
	logic [AXI_AW-1:0] aw_addr_q;
	logic [3:0] w_strb_q;
	logic [3:0] issue;
	logic nxt;

	cfd_flag_if fu_if ();
	cfd_flag_unit u_flag (.fl(fu_if));

	// operands for software-driven flag operations
	assign fu_if.cmd = w_data_q[FOP_CMD_LSB +: 2];
	assign fu_if.acc = a_q;
	assign fu_if.idx = ix_q;
	assign fu_if.opnd = w_data_q[15:0];
	assign fu_if.ccr_in = ccr_q;

	// processor cycle enable and instruction decode
	wire tick = (div_q == DW'(CPU_DIV_P - 1));
	wire op_fetched = fetch_q && (step_q == 4'h0);
	wire [7:0] op_n = op_fetched ? mem_rdata : op_q;
	wire [3:0] cur_act = op_fetched ? ACT_FETCH : cfd_act(op_n, step_q);
	wire last = (step_q == (cfd_ncyc(op_n) - 4'h1));
	wire stopped = (state_q == ST_STOP);
	wire [15:0] rel = {{8{tmp_q[7]}}, tmp_q[7:0]};
	wire [5:0] clr_flags = (ccr_q & ~6'(15)) | 6'(1 << CCR_Z);

	// interrupt pins: a change counts once stages two and three agree
	wire irq_agree = (irq_s_q[1] == irq_s_q[2]);
	wire nmi_agree = (nmi_s_q[1] == nmi_s_q[2]);
	wire nmi_fall = nmi_f_q & nmi_agree & ~nmi_s_q[2];
	wire irq_act = ~irq_f_q;
	// mask already set: only the nmi can release the wait
	wire wake = nmi_pend_q | (irq_act & ~ccr_q[CCR_I]);

	// register bus decode
	wire aw_hs = s_axi_awvalid & awready_q;
	wire w_hs = s_axi_wvalid & wready_q;
	wire wr_go = aw_have_q & w_have_q & ~bvalid_q;
	wire ar_hs = s_axi_arvalid & arready_q;
	wire wr_map = (aw_addr_q[1:0] == 2'h0) && (aw_addr_q <= REG_FLAGOP);
	wire rd_map = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr <= REG_FLAGOP);
	wire wr_en = wr_go & wr_map;
	wire [31:0] rd_word =
		(s_axi_araddr == REG_CTRL) ? {31'h0, run_q} :
		(s_axi_araddr == REG_STATUS) ? {28'h0, nmi_pend_q, ~stopped, ill_q,
			(state_q == ST_WAIT)} :
		(s_axi_araddr == REG_PC) ? {16'h0, pc_q} :
		(s_axi_araddr == REG_SP) ? {16'h0, sp_q} :
		(s_axi_araddr == REG_IX) ? {16'h0, ix_q} :
		(s_axi_araddr == REG_ACC) ? {16'h0, b_q, a_q} :
		(s_axi_araddr == REG_CCR) ? {24'h0, CCR_UNUSED, ccr_q} :
		32'h0;

	// next state of the sequencer and the programmer's registers
	always_comb begin
		state_d = state_q;
		step_d = step_q;
		op_d = op_q;
		stk_d = stk_q;
		tmp_d = tmp_q;
		ret_d = ret_q;
		vec_d = vec_q;
		pc_d = pc_q;
		sp_d = sp_q;
		ix_d = ix_q;
		a_d = a_q;
		b_d = b_q;
		ccr_d = ccr_q;
		run_d = run_q;
		ill_d = ill_q;
		fetch_d = fetch_q;
		nmi_pend_d = nmi_pend_q;
		mem_addr_d = mem_addr_q;
		mem_rd_d = mem_rd_q;
		mem_wr_d = mem_wr_q;
		mem_wdata_d = mem_wdata_q;
		issue = ACT_HOLD;
		nxt = 1'b0;
		// programmer's registers change only while the core is stopped
		if (wr_en) begin
			case (aw_addr_q)
				REG_CTRL: if (w_strb_q[0]) run_d = w_data_q[0];
				REG_STATUS: if (w_strb_q[0] && w_data_q[ST_ILL_BIT]) ill_d = 1'b0;
				REG_PC: if (stopped) pc_d = cfd_merge16(pc_q, w_data_q[15:0], w_strb_q[1:0]);
				REG_SP: if (stopped) sp_d = cfd_merge16(sp_q, w_data_q[15:0], w_strb_q[1:0]);
				REG_IX: if (stopped) ix_d = cfd_merge16(ix_q, w_data_q[15:0], w_strb_q[1:0]);
				REG_ACC: if (stopped) {b_d, a_d} = cfd_merge16({b_q, a_q},
					w_data_q[15:0], w_strb_q[1:0]);
				REG_CCR: if (stopped && w_strb_q[0]) ccr_d = w_data_q[5:0];
				REG_FLAGOP: if (stopped) begin
					ccr_d = fu_if.ccr_out;
					if (fu_if.cmd == FOP_ADD || fu_if.cmd == FOP_DAA) a_d = fu_if.res;
				end
				default: ;
			endcase
		end
		if (tick) begin
			case (state_q)
				ST_STOP: nxt = run_q;
				ST_WAIT: if (!run_q) begin
					state_d = ST_STOP;
					issue = ACT_IDLE;
				end else if (wake) begin
					state_d = ST_RUN;
					op_d = OP_WAKE;
					step_d = 4'h0;
					fetch_d = 1'b0;
					vec_d = nmi_pend_q ? VEC_NMI : VEC_IRQ;
					if (nmi_pend_q) nmi_pend_d = 1'b0;
					issue = ACT_VHI;
				end
				ST_RUN: begin
					// capture what the cycle just ending read
					if (mem_rd_q) tmp_d = {tmp_q[7:0], mem_rdata};
					if (cur_act == ACT_PULL) begin
						stk_d = stk_q + 3'h1;
						case (stk_q)
							3'h0: ccr_d = mem_rdata[5:0];
							3'h1: b_d = mem_rdata;
							3'h2: a_d = mem_rdata;
							3'h3: ix_d[15:8] = mem_rdata;
							3'h4: ix_d[7:0] = mem_rdata;
							3'h5: pc_d[15:8] = mem_rdata;
							default: pc_d[7:0] = mem_rdata;
						endcase
					end
					if (cur_act == ACT_VLO) begin
						pc_d = {tmp_q[7:0], mem_rdata};
						ccr_d[CCR_I] = 1'b1;
					end
					if (op_fetched) begin
						op_d = mem_rdata;
						stk_d = (mem_rdata == OP_RTS) ? STK_PCH : 3'h0;
						ret_d = pc_q + ((mem_rdata == OP_BSR) ? 16'h2 : 16'h1);
						vec_d = VEC_SWI;
					end
					if (op_fetched && !cfd_legal(mem_rdata)) begin
						ill_d = 1'b1;
						run_d = 1'b0;
						state_d = ST_STOP;
						issue = ACT_IDLE;
					end else if (last) begin
						nxt = 1'b1;
						case (op_n)
							OP_BSR: pc_d = ret_q + rel;
							OP_WAI: begin
								pc_d = ret_q;
								state_d = ST_WAIT;
								issue = ACT_IDLE;
								nxt = 1'b0;
							end
							OP_NOP: pc_d = pc_q + 16'h1;
							OP_CLEAR_ACCUMULATOR_A: begin
								a_d = 8'h00;
								ccr_d = clr_flags;
								pc_d = pc_q + 16'h1;
							end
							OP_CLEAR_ACCUMULATOR_B: begin
								b_d = 8'h00;
								ccr_d = clr_flags;
								pc_d = pc_q + 16'h1;
							end
							OP_CLR_EXT: begin
								ccr_d = clr_flags;
								pc_d = pc_q + 16'h3;
							end
							OP_CLR_IDX: begin
								ccr_d = clr_flags;
								pc_d = pc_q + 16'h2;
							end
							OP_CLC, OP_SEC: begin
								ccr_d[CCR_C] = op_n[0];
								pc_d = pc_q + 16'h1;
							end
							OP_CLI, OP_SEI: begin
								ccr_d[CCR_I] = op_n[0];
								pc_d = pc_q + 16'h1;
							end
							OP_CLV, OP_SEV: begin
								ccr_d[CCR_V] = op_n[0];
								pc_d = pc_q + 16'h1;
							end
							default: ;
						endcase
					end else begin
						step_d = step_q + 4'h1;
						issue = cfd_act(op_n, step_q + 4'h1);
					end
				end
				default: state_d = ST_STOP;
			endcase
			// instruction boundary: stop, take an interrupt or fetch
			if (nxt) begin
				state_d = ST_RUN;
				step_d = 4'h0;
				if (!run_q) begin
					state_d = ST_STOP;
					issue = ACT_IDLE;
				end else if (nmi_pend_q || (irq_act && !ccr_d[CCR_I])) begin
					op_d = OP_INT;
					fetch_d = 1'b0;
					stk_d = 3'h0;
					ret_d = pc_d;
					vec_d = nmi_pend_q ? VEC_NMI : VEC_IRQ;
					if (nmi_pend_q) nmi_pend_d = 1'b0;
					issue = ACT_IDLE;
				end else begin
					fetch_d = 1'b1;
					issue = ACT_FETCH;
				end
			end
		end
		// a falling nmi in the clearing cycle is kept
		if (nmi_fall) nmi_pend_d = 1'b1;
		// bus action for the processor cycle that starts now
		case (issue)
			ACT_HOLD: ;
			ACT_FETCH, ACT_RD1, ACT_RD2, ACT_PULL, ACT_VHI, ACT_VLO: begin
				mem_rd_d = 1'b1;
				mem_wr_d = 1'b0;
				mem_addr_d = (issue == ACT_FETCH) ? pc_d :
					(issue == ACT_RD1) ? pc_q + 16'h1 :
					(issue == ACT_RD2) ? pc_q + 16'h2 :
					(issue == ACT_PULL) ? sp_q + 16'h1 :
					(issue == ACT_VHI) ? vec_d : {vec_d[15:1], 1'b1};
				if (issue == ACT_PULL) sp_d = sp_q + 16'h1;
			end
			ACT_PUSH: begin
				mem_rd_d = 1'b0;
				mem_wr_d = 1'b1;
				mem_addr_d = sp_q;
				sp_d = sp_q - 16'h1;
				stk_d = stk_q + 3'h1;
				case (stk_q)
					3'h0: mem_wdata_d = ret_q[7:0];
					3'h1: mem_wdata_d = ret_q[15:8];
					3'h2: mem_wdata_d = ix_q[7:0];
					3'h3: mem_wdata_d = ix_q[15:8];
					3'h4: mem_wdata_d = a_q;
					3'h5: mem_wdata_d = b_q;
					default: mem_wdata_d = {CCR_UNUSED, ccr_q};
				endcase
			end
			ACT_WR0: begin
				mem_rd_d = 1'b0;
				mem_wr_d = 1'b1;
				mem_wdata_d = 8'h00;
				mem_addr_d = (op_n == OP_CLR_EXT) ? tmp_d :
					ix_q + {8'h00, tmp_q[7:0]};
			end
			default: begin
				mem_rd_d = 1'b0;
				mem_wr_d = 1'b0;
			end
		endcase
	end

	// sequencer and register state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= ST_STOP;
			div_q <= '0;
			{step_q, op_q, stk_q, tmp_q, ret_q, vec_q} <= '0;
			{pc_q, sp_q, ccr_q} <= {PC_RST, SP_RST, CCR_RST};
			{ix_q, a_q, b_q} <= '0;
			{run_q, ill_q, fetch_q, nmi_pend_q} <= '0;
			{mem_addr_q, mem_rd_q, mem_wr_q, mem_wdata_q} <= '0;
		end else begin
			state_q <= state_d;
			div_q <= tick ? '0 : div_q + DW'(1);
			{step_q, op_q, stk_q, tmp_q, ret_q, vec_q} <=
				{step_d, op_d, stk_d, tmp_d, ret_d, vec_d};
			{pc_q, sp_q, ix_q, a_q, b_q, ccr_q} <=
				{pc_d, sp_d, ix_d, a_d, b_d, ccr_d};
			{run_q, ill_q, fetch_q, nmi_pend_q} <=
				{run_d, ill_d | (op_fetched & tick & ~cfd_legal(mem_rdata) &
				(state_q == ST_RUN)), fetch_d, nmi_pend_d};
			{mem_addr_q, mem_rd_q, mem_wr_q, mem_wdata_q} <=
				{mem_addr_d, mem_rd_d, mem_wr_d, mem_wdata_d};
		end
	end

	// pin synchronisers; stage one feeds stage two only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{irq_s_q, nmi_s_q} <= 6'h3f;
			{irq_f_q, nmi_f_q} <= 2'h3;
		end else begin
			irq_s_q <= {irq_s_q[1:0], irq_n};
			nmi_s_q <= {nmi_s_q[1:0], nmi_n};
			if (irq_agree) irq_f_q <= irq_s_q[2];
			if (nmi_agree) nmi_f_q <= nmi_s_q[2];
		end
	end

	// register bus slave: one write and one read at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{awready_q, wready_q, arready_q} <= 3'h7;
			{aw_have_q, w_have_q, bvalid_q, rvalid_q} <= '0;
			{bresp_q, rresp_q, rdata_q, w_data_q, aw_addr_q, w_strb_q} <= '0;
		end else begin
			if (aw_hs) {aw_have_q, awready_q, aw_addr_q} <= {2'h2, s_axi_awaddr};
			if (w_hs) {w_have_q, wready_q, w_data_q, w_strb_q} <=
				{2'h2, s_axi_wdata, s_axi_wstrb};
			if (wr_go) begin
				{aw_have_q, w_have_q, bvalid_q} <= 3'h1;
				bresp_q <= wr_map ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid_q && s_axi_bready) {bvalid_q, awready_q, wready_q} <= 3'h3;
			if (ar_hs) begin
				{rvalid_q, arready_q, rdata_q} <= {2'h2, rd_word};
				rresp_q <= rd_map ? RESP_OKAY : RESP_SLVERR;
			end
			if (rvalid_q && s_axi_rready) {rvalid_q, arready_q} <= 2'h1;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign mem_addr = mem_addr_q;
	assign mem_rd = mem_rd_q;
	assign mem_wr = mem_wr_q;
	assign mem_wdata = mem_wdata_q;
endmodule // cfd_core

// ---- common/cfd_pkg.sv ----
package cfd_pkg;
	// clock and processor cycle timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int CPU_CYCLE_NS = 1000;
	localparam int CPU_DIV = (CPU_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// opcodes handled here; 00 and 01 never pass decode, so used internally
	localparam logic [7:0] OP_INT = 8'h00;
	localparam logic [7:0] OP_WAKE = 8'h01;
	localparam logic [7:0] OP_NOP = 8'h02;
	localparam logic [7:0] OP_CLV = 8'h0a;
	localparam logic [7:0] OP_SEV = 8'h0b;
	localparam logic [7:0] OP_CLC = 8'h0c;
	localparam logic [7:0] OP_SEC = 8'h0d;
	localparam logic [7:0] OP_CLI = 8'h0e;
	localparam logic [7:0] OP_SEI = 8'h0f;
	localparam logic [7:0] OP_RTS = 8'h39;
	localparam logic [7:0] OP_RTI = 8'h3b;
	localparam logic [7:0] OP_WAI = 8'h3e;
	localparam logic [7:0] OP_SWI = 8'h3f;
	localparam logic [7:0] OP_CLEAR_ACCUMULATOR_A = 8'h4f;
	localparam logic [7:0] OP_CLEAR_ACCUMULATOR_B = 8'h5f;
	localparam logic [7:0] OP_CLR_IDX = 8'h6f;
	localparam logic [7:0] OP_CLR_EXT = 8'h7f;
	localparam logic [7:0] OP_BSR = 8'h8d;

	// processor cycles per instruction
	localparam logic [3:0] NC_SHORT = 4'h2;
	localparam logic [3:0] NC_BSR = 4'h8;
	localparam logic [3:0] NC_RTS = 4'h5;
	localparam logic [3:0] NC_RTI = 4'ha;
	localparam logic [3:0] NC_SWI = 4'hc;
	localparam logic [3:0] NC_WAI = 4'h9;
	localparam logic [3:0] NC_CLR_EXT = 4'h6;
	localparam logic [3:0] NC_CLR_IDX = 4'h7;

	// condition flag bit positions
	localparam int CCR_C = 0;
	localparam int CCR_V = 1;
	localparam int CCR_Z = 2;
	localparam int CCR_N = 3;
	localparam int CCR_I = 4;
	localparam int CCR_H = 5;
	localparam logic [1:0] CCR_UNUSED = 2'h3;

	// vectors, high byte at the even address
	localparam logic [15:0] VEC_IRQ = 16'hfff8;
	localparam logic [15:0] VEC_SWI = 16'hfffa;
	localparam logic [15:0] VEC_NMI = 16'hfffc;

	// stack slot of the high program counter byte
	localparam logic [2:0] STK_PCH = 3'h5;

	// bus actions of one processor cycle
	localparam logic [3:0] ACT_IDLE = 4'h0;
	localparam logic [3:0] ACT_FETCH = 4'h1;
	localparam logic [3:0] ACT_RD1 = 4'h2;
	localparam logic [3:0] ACT_RD2 = 4'h3;
	localparam logic [3:0] ACT_PUSH = 4'h4;
	localparam logic [3:0] ACT_PULL = 4'h5;
	localparam logic [3:0] ACT_VHI = 4'h6;
	localparam logic [3:0] ACT_VLO = 4'h7;
	localparam logic [3:0] ACT_WR0 = 4'h8;
	localparam logic [3:0] ACT_HOLD = 4'hf;

	// flag unit commands
	localparam logic [1:0] FOP_ADD = 2'h0;
	localparam logic [1:0] FOP_DAA = 2'h1;
	localparam logic [1:0] FOP_CMP = 2'h2;
	localparam logic [1:0] FOP_TAP = 2'h3;
	localparam int FOP_CMD_LSB = 16;

	// register map (byte addresses)
	localparam int AXI_AW = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_PC = 8'h08;
	localparam logic [7:0] REG_SP = 8'h0c;
	localparam logic [7:0] REG_IX = 8'h10;
	localparam logic [7:0] REG_ACC = 8'h14;
	localparam logic [7:0] REG_CCR = 8'h18;
	localparam logic [7:0] REG_FLAGOP = 8'h1c;
	localparam int ST_WAIT_BIT = 0;
	localparam int ST_ILL_BIT = 1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// values after reset
	localparam logic [15:0] PC_RST = 16'h0000;
	localparam logic [15:0] SP_RST = 16'h00ff;
	localparam logic [5:0] CCR_RST = 6'h10;

	typedef enum logic [2:0] {
		ST_STOP = 3'b001,
		ST_RUN = 3'b010,
		ST_WAIT = 3'b100
	} cfd_state_type;
endpackage

// ---- common/cfd_flag_if.sv ----
`timescale 1ns/100ps
interface cfd_flag_if;
	logic [1:0] cmd;
	logic [7:0] acc;
	logic [15:0] idx;
	logic [15:0] opnd;
	logic [5:0] ccr_in;
	logic [5:0] ccr_out;
	logic [7:0] res;
	modport core (output cmd, acc, idx, opnd, ccr_in, input ccr_out, res);
	modport unit (input cmd, acc, idx, opnd, ccr_in, output ccr_out, res);
endinterface

// ---- core/cfd_flag_unit.sv ----
`timescale 1ns/100ps
module cfd_flag_unit
	import cfd_pkg::*;
(
	cfd_flag_if.unit fl
);
	logic [8:0] sum9;
	logic [4:0] sum_lo;
	logic lo_fix;
	logic hi_fix;
	logic [7:0] daa_res;
	logic [16:0] diff17;
	logic [7:0] diff_ms;
	logic [7:0] add_b;

	// byte add with carries out of bit 3 and bit 7
	assign add_b = fl.opnd[7:0];
	assign sum9 = {1'b0, fl.acc} + {1'b0, add_b};
	assign sum_lo = {1'b0, fl.acc[3:0]} + {1'b0, add_b[3:0]};

	// decimal adjust; carry is only ever set, never dropped
	assign lo_fix = (fl.acc[3:0] > 4'h9) | fl.ccr_in[CCR_H];
	assign hi_fix = (fl.acc[7:4] > 4'h9) | fl.ccr_in[CCR_C]
		| ((fl.acc[7:4] > 4'h8) & (fl.acc[3:0] > 4'h9));
	assign daa_res = fl.acc + {(hi_fix ? 4'h6 : 4'h0), (lo_fix ? 4'h6 : 4'h0)};

	// sixteen-bit compare; overflow judged on the high bytes alone
	assign diff17 = {1'b0, fl.idx} - {1'b0, fl.opnd};
	assign diff_ms = fl.idx[15:8] - fl.opnd[15:8];

	always_comb begin
		fl.ccr_out = fl.ccr_in;
		fl.res = fl.acc;
		case (fl.cmd)
			FOP_ADD: begin
				fl.res = sum9[7:0];
				fl.ccr_out[CCR_H] = sum_lo[4];
				fl.ccr_out[CCR_C] = sum9[8];
				fl.ccr_out[CCR_N] = sum9[7];
				fl.ccr_out[CCR_Z] = (sum9[7:0] == 8'h00);
				fl.ccr_out[CCR_V] = (fl.acc[7] == add_b[7]) & (sum9[7] != fl.acc[7]);
			end
			FOP_DAA: begin
				fl.res = daa_res;
				fl.ccr_out[CCR_C] = fl.ccr_in[CCR_C] | hi_fix;
				fl.ccr_out[CCR_N] = daa_res[7];
				fl.ccr_out[CCR_Z] = (daa_res == 8'h00);
			end
			FOP_CMP: begin
				fl.ccr_out[CCR_N] = diff17[15];
				fl.ccr_out[CCR_Z] = (diff17[15:0] == 16'h0000);
				fl.ccr_out[CCR_V] = (fl.idx[15] != fl.opnd[15])
					& (diff_ms[7] != fl.idx[15]);
			end
			FOP_TAP: fl.ccr_out = fl.acc[5:0];
			default: fl.ccr_out = fl.ccr_in;
		endcase
	end
endmodule // cfd_flag_unit

// ---- verif/cfd_mem_model.sv ----
`timescale 1ns/100ps
// program memory and stack behind the core
module cfd_mem_model (
	input logic aclk,
	input logic [15:0] mem_addr,
	input logic mem_rd,
	input logic mem_wr,
	input logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata
);
	logic [7:0] m [0:65535];
	// idle bus shows the inverse, so stale data never passes
	assign mem_rdata = mem_rd ? m[mem_addr] : ~m[mem_addr];
	// write held a whole cycle, rewriting is harmless
	always @(posedge aclk) begin
		if (mem_wr)
			m[mem_addr] <= mem_wdata;
	end
endmodule // cfd_mem_model

// ---- verif/cfd_core_sva.sv ----
`timescale 1ns/100ps
module cfd_core_sva
	import cfd_pkg::*;
#(
	parameter int CPU_DIV_P = CPU_DIV
) (
	input logic aclk,
	input logic aresetn,
	input logic s_axi_awvalid,
	input logic s_axi_awready,
	input logic s_axi_bvalid,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic [AXI_AW-1:0] s_axi_araddr,
	input logic s_axi_rvalid,
	input logic [31:0] s_axi_rdata,
	input logic [1:0] s_axi_rresp,
	input logic [15:0] mem_addr,
	input logic mem_rd,
	input logic mem_wr,
	input logic [7:0] mem_wdata
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// write answer stands one cycle after both halves are held
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready
		|-> ##2 s_axi_bvalid) else $error("no write answer");
	a_aw_refused: assert property (s_axi_awvalid && s_axi_awready
		|=> !s_axi_awready) else $error("aw taken twice");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("no read answer");
	a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready &&
		s_axi_araddr > 8'h1c |=> s_axi_rresp == RESP_SLVERR)
		else $error("unmapped read not refused");
	a_ccr_top_ones: assert property (
		s_axi_arvalid && s_axi_arready && s_axi_araddr == REG_CCR
		|=> s_axi_rdata[7:6] == 2'h3) else $error("ccr top bits");
	// trap vector read in pairs, high byte first
	a_trap_vec_pair: assert property (
		$rose(mem_rd && mem_addr == VEC_SWI)
		|-> ##[1:200] mem_rd && mem_addr == 16'hfffb)
		else $error("trap vector low byte missing");
	a_push_before: assert property (
		$rose(mem_rd && mem_addr == VEC_SWI)
		|-> $past(mem_wr, CPU_DIV_P + 1)) else $error("no stacking");
	// a push keeps address and byte for the cycle (CPU_DIV_P >= 4)
	a_push_stable: assert property ($rose(mem_wr)
		|=> (mem_wr && $stable(mem_addr) && $stable(mem_wdata))[*3])
		else $error("push not held");
endmodule // cfd_core_sva
bind cfd_core cfd_core_sva #(.CPU_DIV_P(CPU_DIV_P)) u_sva (.*);

// ---- verif/test_cfd_core.sv ----
`timescale 1ns/100ps
module test_cfd_core
	import cfd_pkg::*;
;
	logic aclk, aresetn, irq_n, nmi_n, mem_rd, mem_wr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr, mem_wdata, mem_rdata;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r, b;
	logic [15:0] mem_addr;
	int err_total = 0, tests_run = 0, cyc = 0;
	cfd_core #(.CPU_DIV_P(4)) dut (.*);
	cfd_mem_model mem (.aclk(aclk), .mem_addr(mem_addr), .mem_rd(mem_rd),
		.mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	// hang guard, far above the whole run
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_total++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		if (err_total == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, g);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	// address and data offered together, bready held till the answer
	task automatic axw(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		b = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e, string n);
		axr(a);
		chk(n, e, d);
	endtask
	task automatic ld(input logic [15:0] a, input logic [7:0] q[$]);
		foreach (q[i])
			mem.m[a + 16'(i)] = q[i];
	endtask
	// start at pc; an illegal 00 at the end stops the core
	task automatic run(input logic [15:0] pc, sp);
		axw(REG_STATUS, 32'h2);
		axw(REG_PC, {16'h0, pc});
		axw(REG_SP, {16'h0, sp});
		axw(REG_CTRL, 32'h1);
		do
			axr(REG_CTRL);
		while (d[0]);
	endtask
	task automatic t_flags();
		ld(16'h0, '{8'h02, 8'h0d, 8'h0b, 8'h0f, 8'h00});
		axw(REG_CCR, 32'h20);
		run(16'h0, 16'hff);
		rc(REG_CCR, 32'hf3, "ccr set");
		rc(REG_PC, 32'h4, "pc nop");
		ld(16'h10, '{8'h0c, 8'h0a, 8'h0e, 8'h00});
		axw(REG_CCR, 32'h3f);
		run(16'h10, 16'hff);
		rc(REG_CCR, 32'hec, "ccr clear");
	endtask
	task automatic t_clear();
		ld(16'h20, '{8'h4f, 8'h5f, 8'h00});
		axw(REG_ACC, 32'ha55a);
		axw(REG_CCR, 32'h2b);
		run(16'h20, 16'hff);
		rc(REG_ACC, 32'h0, "acc");
		rc(REG_CCR, 32'he4, "ccr clr");
	endtask
	// one backward and one forward call, each returning
	task automatic t_call();
		ld(16'h40, '{8'h39});
		ld(16'h60, '{8'h8d, 8'hde, 8'h8d, 8'h0e, 8'h00});
		ld(16'h72, '{8'h39});
		run(16'h60, 16'hff);
		rc(REG_PC, 32'h64, "pc call");
		rc(REG_SP, 32'hff, "sp call");
		chk("ret lo", 32'h64, {24'h0, mem.m[16'hff]});
	endtask
	// trap into a handler that returns at once
	task automatic t_trap();
		ld(16'hfffa, '{8'h01, 8'h00});
		ld(16'h100, '{8'h3b});
		ld(16'h30, '{8'h3f, 8'h00});
		axw(REG_IX, 32'h1234);
		axw(REG_ACC, 32'ha55a);
		axw(REG_CCR, 32'h01);
		run(16'h30, 16'h8f);
		rc(REG_PC, 32'h31, "pc trap");
		rc(REG_CCR, 32'hc1, "ccr rti");
		chk("stk ix", 32'h34, {24'h0, mem.m[16'h8d]});
	endtask
	// mask set: low irq must not wake, nmi must
	task automatic t_wait();
		ld(16'hfffc, '{8'h01, 8'h20});
		ld(16'h120, '{8'h00});
		ld(16'h50, '{8'h3e});
		axw(REG_CCR, 32'h10);
		axw(REG_STATUS, 32'h2);
		axw(REG_PC, 32'h50);
		axw(REG_CTRL, 32'h1);
		irq_n <= 1'b0;
		do
			axr(REG_STATUS);
		while (!d[0]);
		repeat (40) @(posedge aclk);
		rc(REG_STATUS, 32'h5, "waiting");
		nmi_n <= 1'b0;
		do
			axr(REG_CTRL);
		while (d[0]);
		irq_n <= 1'b1;
		nmi_n <= 1'b1;
		rc(REG_PC, 32'h120, "pc nmi");
		rc(REG_CCR, 32'hd0, "ccr nmi");
	endtask
	task automatic t_alu();
		axw(REG_CCR, 32'h0);
		axw(REG_ACC, 32'h08);
		axw(REG_FLAGOP, 32'h08);
		rc(REG_CCR, 32'he0, "half");
		axw(REG_FLAGOP, 32'hf0);
		rc(REG_CCR, 32'hc5, "carry");
		axw(REG_ACC, 32'h2a);
		axw(REG_FLAGOP, 32'h30000);
		rc(REG_CCR, 32'hea, "tap");
		axw(REG_CCR, 32'h0);
		axw(REG_ACC, 32'h9a);
		axw(REG_FLAGOP, 32'h10000);
		rc(REG_CCR, 32'hc5, "daa");
		axw(REG_ACC, 32'h12);
		axw(REG_FLAGOP, 32'h10000);
		rc(REG_CCR, 32'hc1, "daa keep");
		axw(REG_IX, 32'h8000);
		axw(REG_FLAGOP, 32'h20100);
		rc(REG_CCR, 32'hc3, "cmp v");
		axw(REG_IX, 32'h0);
		axw(REG_FLAGOP, 32'h20001);
		rc(REG_CCR, 32'hc9, "cmp n");
	endtask
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready, irq_n, nmi_n} = 4'h3;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hf;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rc(REG_CCR, 32'hd0, "ccr reset");
		axr(8'h20);
		chk("unmapped", 32'h2, {30'h0, r});
		axw(8'h22, 32'h0);
		chk("unmapped wr", 32'h2, {30'h0, b});
		t_flags();
		t_clear();
		t_call();
		t_trap();
		t_wait();
		t_alu();
		report_and_stop();
	end
endmodule // test_cfd_core
